// [smrd_params.svh]
// mode register decode: select codes, field positions, reset values, latency figures
`ifndef SMRD_PARAMS_SVH
`define SMRD_PARAMS_SVH

`define SMRD_SEL_MR1       3'h1
`define SMRD_SEL_MR2       3'h2
`define SMRD_SEL_MR3       3'h3
`define SMRD_SEL_XRCW      3'h7

`define SMRD_A_TOP         17
`define SMRD_A_13          13
`define SMRD_QOFF          12
`define SMRD_NOM_HI        10
`define SMRD_NOM_LO        8
`define SMRD_DRV_HI        2
`define SMRD_DRV_LO        1
`define SMRD_CRC           12
`define SMRD_WTERM_HI      10
`define SMRD_WTERM_LO      9
`define SMRD_SR_HI         7
`define SMRD_SR_LO         6
`define SMRD_WL_HI         5
`define SMRD_WL_LO         3
`define SMRD_FMT_HI        12
`define SMRD_FMT_LO        11
`define SMRD_CDL_HI        10
`define SMRD_CDL_LO        9
`define SMRD_FGR_HI        8
`define SMRD_FGR_LO        6
`define SMRD_TEMP          5
`define SMRD_PDA           4
`define SMRD_GEAR          3
`define SMRD_MPR_OP        2
`define SMRD_PAGE_HI       1
`define SMRD_PAGE_LO       0

`define SMRD_MR_RESET      18'h00000

`define SMRD_WL_0          5'h09
`define SMRD_WL_1          5'h0a
`define SMRD_WL_2          5'h0b
`define SMRD_WL_3          5'h0c
`define SMRD_WL_4          5'h0e
`define SMRD_WL_5          5'h10
`define SMRD_WL_6          5'h12
`define SMRD_CDL_0         3'h4
`define SMRD_CDL_1         3'h5
`define SMRD_CDL_2         3'h6

`endif

// [smrd_pkg.sv]
// mode register decode: types shared by the link and core logic
package smrd_pkg;

  typedef struct packed {
    logic [2:0]  sel;
    logic [17:0] addr;
  } smrd_mrs_s;

  typedef enum logic [2:0] {
    NT_OFF  = 3'b000, NT_DIV4 = 3'b001, NT_DIV2 = 3'b010, NT_DIV6 = 3'b011,
    NT_DIV1 = 3'b100, NT_DIV5 = 3'b101, NT_DIV3 = 3'b110, NT_DIV7 = 3'b111
  } smrd_nom_term_e;

  typedef enum logic [1:0] {
    DS_DIV7 = 2'b00, DS_DIV5 = 2'b01, DS_RSV2 = 2'b10, DS_RSV3 = 2'b11
  } smrd_drive_e;

  typedef enum logic [1:0] {
    WT_OFF = 2'b00, WT_DIV2 = 2'b01, WT_DIV1 = 2'b10, WT_HIZ = 2'b11
  } smrd_wr_term_e;

  typedef enum logic [1:0] {
    SR_NORMAL = 2'b00, SR_REDUCED = 2'b01, SR_EXTENDED = 2'b10, SR_AUTO = 2'b11
  } smrd_self_ref_e;

  typedef enum logic [2:0] {
    RF_FIX1 = 3'b000, RF_FIX2 = 3'b001, RF_FIX4 = 3'b010, RF_RSV3 = 3'b011,
    RF_RSV4 = 3'b100, RF_OTF2 = 3'b101, RF_OTF4 = 3'b110, RF_RSV7 = 3'b111
  } smrd_refresh_e;

  typedef enum logic [1:0] {
    RD_SERIAL = 2'b00, RD_PARALLEL = 2'b01, RD_STAGGERED = 2'b10, RD_RSV = 2'b11
  } smrd_rd_fmt_e;

endpackage

// [smrd_word_sync.sv]
// toggle handshake that carries one mode register word between two clocks
module smrd_word_sync (
  input  wire logic              i_src_clk,
  input  wire logic              i_dst_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_src_valid,
  input  smrd_pkg::smrd_mrs_s    i_src_word,
  output logic                   o_src_ready,
  output logic                   o_dst_valid,
  output smrd_pkg::smrd_mrs_s    o_dst_word
);

  logic                req;
  logic                ack_s1;
  logic                ack_s2;
  smrd_pkg::smrd_mrs_s hold;
  logic                req_s1;
  logic                req_s2;
  logic                req_s3;

  // word is held still until the far side has toggled back
  assign o_src_ready = (req == ack_s2);

  always_ff @(posedge i_src_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req  <= 1'b0;
      hold <= '0;
    end else if (i_src_valid && o_src_ready) begin
      req  <= ~req;
      hold <= i_src_word;
    end
  end

  always_ff @(posedge i_src_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= req_s3;
      ack_s2 <= ack_s1;
    end
  end

  always_ff @(posedge i_dst_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  always_ff @(posedge i_dst_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dst_valid <= 1'b0;
      o_dst_word  <= '0;
    end else begin
      o_dst_valid <= req_s2 ^ req_s3;
      if (req_s2 ^ req_s3) begin
        o_dst_word <= hold;
      end
    end
  end

endmodule

// [smrd_mode_decode.sv]
// mode register capture on the link clock and field decode on the core clock
`include "smrd_params.svh"

// Operation
// - select code 111 commands are silently ignored
// - decode nominal termination field to resistor divisor
// - decode driver strength; codes 10, 11 reserved
// - buffer disable turns off data and strobes
// - decode array self-refresh mode field
// - decode write latency: 9..18 clocks, 111 reserved
// - decode refresh granularity; 011, 100, 111 reserved
// - crc plus mask adds 4, 5, 6 clocks
// - multipurpose operation routes data to selected page
// - decode multipurpose read format; 11 reserved
// - first register bit 12 disables output buffers
// - first register bits 10..8 hold termination
module smrd_mode_decode (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_link_clk,
  input  wire logic                    i_mrs_cmd,
  input  wire logic [2:0]              i_reg_select,
  input  wire logic [17:0]             i_addr,
  input  wire logic                    i_data_mask_en,
  output logic                         o_output_buffer_off,
  output logic                         o_data_out_en,
  output logic                         o_strobe_true_en,
  output logic                         o_strobe_comp_en,
  output smrd_pkg::smrd_nom_term_e     o_nominal_term,
  output smrd_pkg::smrd_drive_e        o_drive_strength,
  output logic                         o_drive_reserved,
  output logic                         o_write_crc_en,
  output smrd_pkg::smrd_wr_term_e      o_write_term,
  output smrd_pkg::smrd_self_ref_e     o_self_refresh_mode,
  output logic [4:0]                   o_write_latency,
  output logic                         o_write_latency_reserved,
  output smrd_pkg::smrd_refresh_e      o_refresh_mode,
  output logic                         o_refresh_reserved,
  output logic [2:0]                   o_crc_dm_adder,
  output logic                         o_crc_dm_reserved,
  output logic [5:0]                   o_write_cmd_latency,
  output logic                         o_mpr_enable,
  output logic [1:0]                   o_mpr_page,
  output smrd_pkg::smrd_rd_fmt_e       o_mpr_read_format,
  output logic                         o_mpr_format_reserved,
  output logic                         o_temp_readout_en,
  output logic                         o_per_device_addr_en,
  output logic                         o_geardown_quarter,
  output logic [17:0]                  o_write_path_mode,
  output logic [17:0]                  o_mpr_refresh_mode,
  output logic                         o_reserved_bits_seen,
  output logic                         o_update
);

  // ---------------- link domain ----------------
  // command pins are launched on the link clock, so they are sampled directly
  smrd_pkg::smrd_mrs_s pend_word;
  logic                pend;
  logic                src_ready;
  logic                take;
  logic                send;

  assign take = i_mrs_cmd && (i_reg_select != `SMRD_SEL_XRCW);
  assign send = pend && src_ready;

  // one-deep slot: a newer command overwrites an unsent older one, which is
  // harmless since spaced commands leave ample time for the handshake
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend      <= 1'b0;
      pend_word <= '0;
    end else if (take) begin
      pend      <= 1'b1;
      pend_word <= '{sel: i_reg_select, addr: i_addr};
    end else if (send) begin
      pend <= 1'b0;
    end
  end

  rcw_ignored_a: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_n)
    i_mrs_cmd && i_reg_select == `SMRD_SEL_XRCW && !pend |=> !pend)
    else $error("external control word command was not ignored");

  pend_set_a: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_n)
    i_mrs_cmd && i_reg_select != `SMRD_SEL_XRCW |=> pend)
    else $error("accepted command was not held for the crossing");

  // ---------------- crossing ----------------
  logic                rx_valid;
  smrd_pkg::smrd_mrs_s rx_word;

  smrd_word_sync u_sync (
    .i_src_clk   (i_link_clk),
    .i_dst_clk   (i_clock),
    .i_rst_n     (i_rst_n),
    .i_src_valid (pend),
    .i_src_word  (pend_word),
    .o_src_ready (src_ready),
    .o_dst_valid (rx_valid),
    .o_dst_word  (rx_word)
  );

  // ---------------- core domain ----------------
  logic        hit_mr1;
  logic        hit_mr2;
  logic        hit_mr3;
  logic [17:0] a;

  assign a       = rx_word.addr;
  assign hit_mr1 = rx_valid && rx_word.sel == `SMRD_SEL_MR1;
  assign hit_mr2 = rx_valid && rx_word.sel == `SMRD_SEL_MR2;
  assign hit_mr3 = rx_valid && rx_word.sel == `SMRD_SEL_MR3;

  function automatic logic [4:0] wl_decode(input logic [2:0] code);
    logic [4:0] v;
    v = 5'h00;
    unique case (code)
      3'b000: v = `SMRD_WL_0;
      3'b001: v = `SMRD_WL_1;
      3'b010: v = `SMRD_WL_2;
      3'b011: v = `SMRD_WL_3;
      3'b100: v = `SMRD_WL_4;
      3'b101: v = `SMRD_WL_5;
      3'b110: v = `SMRD_WL_6;
      3'b111: v = 5'h00;
    endcase
    return v;
  endfunction

  function automatic logic [2:0] cdl_decode(input logic [1:0] code);
    logic [2:0] v;
    v = 3'h0;
    unique case (code)
      2'b00: v = `SMRD_CDL_0;
      2'b01: v = `SMRD_CDL_1;
      2'b10: v = `SMRD_CDL_2;
      2'b11: v = 3'h0;
    endcase
    return v;
  endfunction

  // first register: only the termination, driver and buffer fields live here
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_output_buffer_off <= 1'b0;
      o_data_out_en       <= 1'b1;
      o_strobe_true_en    <= 1'b1;
      o_strobe_comp_en    <= 1'b1;
      o_nominal_term      <= smrd_pkg::NT_OFF;
      o_drive_strength    <= smrd_pkg::DS_DIV7;
      o_drive_reserved    <= 1'b0;
    end else if (hit_mr1) begin
      o_output_buffer_off <= a[`SMRD_QOFF];
      o_data_out_en       <= !a[`SMRD_QOFF];
      o_strobe_true_en    <= !a[`SMRD_QOFF];
      o_strobe_comp_en    <= !a[`SMRD_QOFF];
      o_nominal_term      <=
        smrd_pkg::smrd_nom_term_e'(a[`SMRD_NOM_HI:`SMRD_NOM_LO]);
      o_drive_strength    <= smrd_pkg::smrd_drive_e'(a[`SMRD_DRV_HI:`SMRD_DRV_LO]);
      o_drive_reserved    <= a[`SMRD_DRV_HI];
    end
  end

  // write path register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_write_path_mode        <= `SMRD_MR_RESET;
      o_write_crc_en           <= 1'b0;
      o_write_term             <= smrd_pkg::WT_OFF;
      o_self_refresh_mode      <= smrd_pkg::SR_NORMAL;
      o_write_latency          <= `SMRD_WL_0;
      o_write_latency_reserved <= 1'b0;
    end else if (hit_mr2) begin
      o_write_path_mode        <= a;
      o_write_crc_en           <= a[`SMRD_CRC];
      o_write_term             <=
        smrd_pkg::smrd_wr_term_e'(a[`SMRD_WTERM_HI:`SMRD_WTERM_LO]);
      o_self_refresh_mode      <=
        smrd_pkg::smrd_self_ref_e'(a[`SMRD_SR_HI:`SMRD_SR_LO]);
      o_write_latency          <= wl_decode(a[`SMRD_WL_HI:`SMRD_WL_LO]);
      o_write_latency_reserved <= &a[`SMRD_WL_HI:`SMRD_WL_LO];
    end
  end

  // multipurpose and refresh register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mpr_refresh_mode    <= `SMRD_MR_RESET;
      o_mpr_read_format     <= smrd_pkg::RD_SERIAL;
      o_mpr_format_reserved <= 1'b0;
      o_crc_dm_adder        <= `SMRD_CDL_0;
      o_crc_dm_reserved     <= 1'b0;
      o_refresh_mode        <= smrd_pkg::RF_FIX1;
      o_refresh_reserved    <= 1'b0;
      o_temp_readout_en     <= 1'b0;
      o_per_device_addr_en  <= 1'b0;
      o_geardown_quarter    <= 1'b0;
      o_mpr_enable          <= 1'b0;
      o_mpr_page            <= 2'h0;
    end else if (hit_mr3) begin
      o_mpr_refresh_mode    <= a;
      o_mpr_read_format     <= smrd_pkg::smrd_rd_fmt_e'(a[`SMRD_FMT_HI:`SMRD_FMT_LO]);
      o_mpr_format_reserved <= &a[`SMRD_FMT_HI:`SMRD_FMT_LO];
      o_crc_dm_adder        <= cdl_decode(a[`SMRD_CDL_HI:`SMRD_CDL_LO]);
      o_crc_dm_reserved     <= &a[`SMRD_CDL_HI:`SMRD_CDL_LO];
      o_refresh_mode        <=
        smrd_pkg::smrd_refresh_e'(a[`SMRD_FGR_HI:`SMRD_FGR_LO]);
      o_refresh_reserved    <= (a[`SMRD_FGR_HI:`SMRD_FGR_LO] == 3'b011) ||
                               (a[`SMRD_FGR_HI:`SMRD_FGR_LO] == 3'b100) ||
                               (a[`SMRD_FGR_HI:`SMRD_FGR_LO] == 3'b111);
      o_temp_readout_en     <= a[`SMRD_TEMP];
      o_per_device_addr_en  <= a[`SMRD_PDA];
      o_geardown_quarter    <= a[`SMRD_GEAR];
      o_mpr_enable          <= a[`SMRD_MPR_OP];
      o_mpr_page            <= a[`SMRD_PAGE_HI:`SMRD_PAGE_LO];
    end
  end

  // the adder only applies when both crc and mask are on; follows the
  // registered fields, so it settles one cycle after a register update
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_write_cmd_latency <= 6'h00;
    end else if (o_write_crc_en && i_data_mask_en) begin
      o_write_cmd_latency <= {1'b0, o_write_latency} + {3'b000, o_crc_dm_adder};
    end else begin
      o_write_cmd_latency <= {1'b0, o_write_latency};
    end
  end

  // reserved address bits are not policed, only reported; the word is still used
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reserved_bits_seen <= 1'b0;
      o_update             <= 1'b0;
    end else begin
      o_update <= hit_mr1 || hit_mr2 || hit_mr3;
      if (rx_valid) begin
        o_reserved_bits_seen <= a[`SMRD_A_TOP] || a[`SMRD_A_13];
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  nom_term_a: assert property (
    hit_mr1 |=> o_nominal_term == $past(rx_word.addr[10:8]))
    else $error("nominal termination not taken from bits 10..8");

  buffer_off_a: assert property (
    o_output_buffer_off |-> !o_data_out_en && !o_strobe_true_en && !o_strobe_comp_en)
    else $error("outputs still enabled while buffers are off");

  qoff_bit_a: assert property (
    hit_mr1 |=> o_output_buffer_off == $past(rx_word.addr[12]))
    else $error("buffer disable not taken from bit 12");

  drive_rsv_a: assert property (
    hit_mr1 |=> o_drive_reserved == $past(rx_word.addr[2]) &&
                o_drive_strength == $past(rx_word.addr[2:1]))
    else $error("driver strength decode wrong");

  write_term_a: assert property (
    hit_mr2 |=> o_write_term == $past(rx_word.addr[10:9]))
    else $error("write termination decode wrong");

  self_ref_a: assert property (
    hit_mr2 |=> o_self_refresh_mode == $past(rx_word.addr[7:6]))
    else $error("self-refresh mode decode wrong");

  write_lat_a: assert property (
    hit_mr2 && rx_word.addr[5:3] == 3'b100 |=> o_write_latency == 5'h0e &&
                                               !o_write_latency_reserved)
    else $error("write latency code 100 must give 14 clocks");

  refresh_rsv_a: assert property (
    hit_mr3 && rx_word.addr[8:6] == 3'b100 |=> o_refresh_reserved)
    else $error("refresh code 100 must be flagged reserved");

  crc_dm_add_a: assert property (
    o_write_crc_en && i_data_mask_en && o_crc_dm_adder == 3'h5 && !rx_valid
    |=> o_write_cmd_latency == {1'b0, $past(o_write_latency)} + 6'h05)
    else $error("crc plus mask latency adder not applied");

  mpr_page_a: assert property (
    hit_mr3 |=> o_mpr_enable == $past(rx_word.addr[2]) &&
                o_mpr_page == $past(rx_word.addr[1:0]))
    else $error("multipurpose operation or page decode wrong");

  read_fmt_a: assert property (
    hit_mr3 |=> o_mpr_read_format == $past(rx_word.addr[12:11]) &&
                o_mpr_format_reserved == (&$past(rx_word.addr[12:11])))
    else $error("multipurpose read format decode wrong");

  fields_hold_a: assert property (
    !rx_valid |=> $stable(o_write_path_mode) && $stable(o_mpr_refresh_mode) &&
                  $stable(o_nominal_term))
    else $error("mode fields changed without a command");

  wl_top_a: assert property (
    hit_mr2 && rx_word.addr[5:3] == 3'b110 |=> o_write_latency == 5'h12)
    else $error("write latency code 110 must give 18 clocks");

  wl_rsv_a: assert property (
    hit_mr2 |=> o_write_latency_reserved == (&$past(rx_word.addr[5:3])))
    else $error("write latency reserved flag wrong");

  crc_bit_a: assert property (
    hit_mr2 |=> o_write_crc_en == $past(rx_word.addr[12]))
    else $error("write crc enable not taken from bit 12");

  crc_dm_rsv_a: assert property (
    hit_mr3 |=> o_crc_dm_reserved == (&$past(rx_word.addr[10:9])))
    else $error("crc plus mask reserved flag wrong");

  no_adder_a: assert property (
    !(o_write_crc_en && i_data_mask_en) |=> o_write_cmd_latency == {1'b0, $past(o_write_latency)})
    else $error("latency adder applied without crc and mask");

  refresh_otf_a: assert property (
    hit_mr3 && rx_word.addr[8:6] == 3'b101 |=> !o_refresh_reserved &&
                                               o_refresh_mode == smrd_pkg::RF_OTF2)
    else $error("refresh code 101 must be on-the-fly 2x");

  misc_bits_a: assert property (
    hit_mr3 |=> {o_temp_readout_en, o_per_device_addr_en, o_geardown_quarter} ==
                $past(rx_word.addr[5:3]))
    else $error("sensor, addressability or geardown bits wrong");

  update_pulse_a: assert property (
    hit_mr1 || hit_mr2 || hit_mr3 |=> o_update)
    else $error("update pulse missing after register write");

  rsv_bits_a: assert property (
    rx_valid |=> o_reserved_bits_seen == ($past(rx_word.addr[17]) || $past(rx_word.addr[13])))
    else $error("reserved address bit report wrong");

  mr1_hold_a: assert property (
    !hit_mr1 |=> $stable(o_output_buffer_off) && $stable(o_drive_strength))
    else $error("first register fields changed without a command");

endmodule

// [smrd_ctrl_model.sv]
// controller stand-in that issues mode register set commands on the link clock
module smrd_ctrl_model (
  input  wire logic        i_link_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_go,
  input  wire logic [2:0]  i_sel,
  input  wire logic [17:0] i_addr,
  input  wire logic        i_allow_rsv,
  output logic             o_mrs_cmd,
  output logic [2:0]       o_reg_select,
  output logic [17:0]      o_addr,
  output logic             o_done
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mrs_cmd    <= 1'b0;
      o_reg_select <= 3'h0;
      o_addr       <= 18'h00000;
      o_done       <= 1'b0;
    end else if (i_go && !o_done) begin
      o_mrs_cmd    <= 1'b1;
      o_reg_select <= i_sel;
      // top bit and bit 13 go out low unless a scenario breaks this on purpose
      o_addr       <= i_allow_rsv ? i_addr : (i_addr & 18'h1dfff);
      o_done       <= 1'b1;
    end else begin
      // pins carry nothing between commands, so keep them moving
      o_mrs_cmd    <= 1'b0;
      o_reg_select <= ~o_reg_select;
      o_addr       <= ~o_addr;
      o_done       <= i_go;
    end
  end
endmodule

// [sdram_mode_register_decode_test.sv]
// self-checking bench for the mode register decode
module sdram_mode_register_decode_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clock = 1'b0;
  logic        i_link_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        go = 1'b0;
  logic        allow_rsv = 1'b0;
  logic        dm_en = 1'b0;
  logic [2:0]  go_sel = 3'h0;
  logic [17:0] go_addr = 18'h00000;
  logic        mrs_cmd, done;
  logic [2:0]  reg_sel;
  logic [17:0] addr;
  logic        qoff, dq_en, st_en, sc_en, drv_rsv, crc_en, wl_rsv, rf_rsv, ad_rsv;
  logic        mpr_en, fmt_rsv, temp_en, pda_en, gear, rsv_seen, upd;
  logic [2:0]  nom, rf, adder;
  logic [1:0]  drv, wterm, sref, page, fmt;
  logic [4:0]  wl;
  logic [5:0]  wcl;
  logic [17:0] wp_raw, mr_raw, mr1, mr2, mr3;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  always #10 i_clock = ~i_clock;
  initial begin
    #3.3;
    forever #6 i_link_clk = ~i_link_clk;
  end

  smrd_ctrl_model u_smrd_ctrl_model (.i_link_clk(i_link_clk), .i_rst_n(i_rst_n), .i_go(go),
    .i_sel(go_sel), .i_addr(go_addr), .i_allow_rsv(allow_rsv), .o_mrs_cmd(mrs_cmd),
    .o_reg_select(reg_sel), .o_addr(addr), .o_done(done));

  smrd_mode_decode u_smrd_mode_decode (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_link_clk(i_link_clk), .i_mrs_cmd(mrs_cmd), .i_reg_select(reg_sel), .i_addr(addr),
    .i_data_mask_en(dm_en), .o_output_buffer_off(qoff), .o_data_out_en(dq_en),
    .o_strobe_true_en(st_en), .o_strobe_comp_en(sc_en), .o_nominal_term(nom),
    .o_drive_strength(drv), .o_drive_reserved(drv_rsv), .o_write_crc_en(crc_en),
    .o_write_term(wterm), .o_self_refresh_mode(sref), .o_write_latency(wl),
    .o_write_latency_reserved(wl_rsv), .o_refresh_mode(rf), .o_refresh_reserved(rf_rsv),
    .o_crc_dm_adder(adder), .o_crc_dm_reserved(ad_rsv), .o_write_cmd_latency(wcl),
    .o_mpr_enable(mpr_en), .o_mpr_page(page), .o_mpr_read_format(fmt),
    .o_mpr_format_reserved(fmt_rsv), .o_temp_readout_en(temp_en),
    .o_per_device_addr_en(pda_en), .o_geardown_quarter(gear), .o_write_path_mode(wp_raw),
    .o_mpr_refresh_mode(mr_raw), .o_reserved_bits_seen(rsv_seen), .o_update(upd));

  function automatic logic [4:0] exp_wl(input logic [2:0] c);
    logic [4:0] t [8] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h00};
    return t[c];
  endfunction

  function automatic logic [2:0] exp_add(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'h4 + {1'b0, c};
  endfunction

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic check_all();
    logic [4:0] w;
    logic [2:0] a;
    w = exp_wl(mr2[5:3]);
    a = exp_add(mr3[10:9]);
    chk("qoff", qoff, mr1[12]);
    chk("dq_en", dq_en, !mr1[12]);
    chk("strobe_t_en", st_en, !mr1[12]);
    chk("strobe_c_en", sc_en, !mr1[12]);
    chk("nom_term", nom, mr1[10:8]);
    chk("drive", drv, mr1[2:1]);
    chk("drive_rsv", drv_rsv, mr1[2]);
    chk("crc_en", crc_en, mr2[12]);
    chk("wr_term", wterm, mr2[10:9]);
    chk("self_ref", sref, mr2[7:6]);
    chk("wl", wl, w);
    chk("wl_rsv", wl_rsv, mr2[5:3] == 3'h7);
    chk("refresh", rf, mr3[8:6]);
    chk("refresh_rsv", rf_rsv, mr3[8:6] inside {3'h3, 3'h4, 3'h7});
    chk("adder", adder, a);
    chk("adder_rsv", ad_rsv, mr3[10:9] == 2'h3);
    chk("wr_cmd_lat", wcl, w + ((mr2[12] && dm_en) ? a : 3'h0));
    chk("mpr_en", mpr_en, mr3[2]);
    chk("mpr_page", page, mr3[1:0]);
    chk("rd_fmt", fmt, mr3[12:11]);
    chk("fmt_rsv", fmt_rsv, mr3[12:11] == 2'h3);
    chk("misc", {temp_en, pda_en, gear}, mr3[5:3]);
    chk("wp_raw", wp_raw, mr2);
    chk("mr_raw", mr_raw, mr3);
  endtask

  // hold the request until the model has issued it, then leave room for the crossing
  task automatic send(input logic [2:0] sel, input logic [17:0] a, input logic upd_exp);
    int n;
    logic seen;
    seen = 1'b0;
    @(posedge i_clock) #1;
    go_sel = sel;
    go_addr = a;
    go = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge i_clock) #1;
      n++;
    end
    go = 1'b0;
    for (n = 0; n < 30; n++) begin
      @(posedge i_clock) #1;
      if (upd === 1'b1)
        seen = 1'b1;
    end
    chk("update", seen, upd_exp);
  endtask

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    logic [17:0] a;
    logic [2:0]  s;
    logic [2:0]  c3;
    mr1 = 18'h00000;
    mr2 = 18'h00000;
    mr3 = 18'h00000;
    void'($urandom(93412));
    repeat (10) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    check_all();
    // every code of every multi-bit field but the page, random filler in the other bits save 17 and 13;
    // reserved codes are sent on purpose and both their flags and decoded values are judged
    for (int k = 0; k < 24; k++) begin
      s = 3'(1 + k % 3);
      c3 = 3'(k / 3);
      a = 18'($urandom) & 18'h1dfff;
      dm_en = 1'($urandom);
      case (s)
        3'h1: begin
          a[10:8] = c3;
          a[2:1] = c3[1:0];
          mr1 = a;
        end
        3'h2: begin
          a[5:3] = c3;
          a[10:9] = c3[1:0];
          a[7:6] = c3[1:0];
          mr2 = a;
        end
        default: begin
          a[8:6] = c3;
          a[10:9] = c3[1:0];
          a[12:11] = c3[1:0];
          mr3 = a;
        end
      endcase
      send(s, a, 1'b1);
      check_all();
      dm_en = !dm_en;
      repeat (2) @(posedge i_clock) #1;
      check_all();
    end
    // unused selects change nothing; reserved address bits are only reported
    allow_rsv = 1'b1;
    send(3'h0, 18'h22000, 1'b0);
    chk("rsv_seen", rsv_seen, 1'b1);
    allow_rsv = 1'b0;
    send(3'h7, 18'h1dfff, 1'b0);
    chk("rsv_kept", rsv_seen, 1'b1);
    check_all();
    for (int j = 4; j < 7; j++) begin
      send(3'(j), 18'($urandom), 1'b0);
      check_all();
    end
    chk("rsv_clear", rsv_seen, 1'b0);
    // a second reset in mid-run returns every field to its start value
    i_rst_n = 1'b0;
    mr1 = 18'h00000;
    mr2 = 18'h00000;
    mr3 = 18'h00000;
    repeat (4) @(posedge i_clock) #1;
    i_rst_n = 1'b1;
    repeat (3) @(posedge i_clock) #1;
    check_all();
    tally_and_finish();
  end
endmodule
